// File: inc/radio_state_pkg.sv
// constants for the radio state policy configuration block
// assumes one control clock; register offsets are on the device register port
package radio_state_pkg;

  // ----------------------------------------------------------------
  // register offsets and widths
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 8;
  localparam logic [5:0] RADIO_STATE_CONFIG_1_OFS = 6'h17;
  localparam logic [5:0] RADIO_STATE_CONFIG_0_OFS = 6'h18;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned CRITERION_LSB   = 4;
  localparam int unsigned AFTER_RX_LSB    = 2;
  localparam int unsigned AFTER_TX_LSB    = 0;
  localparam int unsigned AUTOCAL_LSB     = 4;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] CRITERION_RST = 2'h3;
  localparam logic [1:0] AFTER_RX_RST  = 2'h0;
  localparam logic [1:0] AFTER_TX_RST  = 2'h0;
  localparam logic [1:0] AUTOCAL_RST   = 2'h0;

  // ----------------------------------------------------------------
  // field encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] CRIT_ALWAYS     = 2'h0;
  localparam logic [1:0] CRIT_BELOW_THR  = 2'h1;
  localparam logic [1:0] CRIT_NOT_RX     = 2'h2;
  localparam logic [1:0] CRIT_BOTH       = 2'h3;
  localparam logic [1:0] CAL_NEVER       = 2'h0;
  localparam logic [1:0] CAL_LEAVE_IDLE  = 2'h1;
  localparam logic [1:0] CAL_AUTO_IDLE   = 2'h2;
  localparam logic [1:0] CAL_FOURTH_IDLE = 2'h3;
  localparam logic [1:0] FOURTH_LAST     = 2'h3;

  // radio states handed to the main control state machine
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SYNTH_ON_FOR_TRANSMIT,
    ST_TRANSMIT,
    ST_RECEIVE
  } radio_state_t;

endpackage : radio_state_pkg

// File: logic/radio_state_policy_config.sv
// policy registers of the main radio control state machine
// assumes register port and radio event inputs are synchronous to ref_clk_in
`timescale 1ns/1ns

// What this block does
// (RL1) criterion 0 always clear, 1 strength low, 2 not receiving, 3 both.
// (RL2) clear-channel indication follows selected criterion; criterion resets to 3.
// (RL3) after receive: idle, synth on, transmit or stay receive; resets 0.
// (RL4) after transmit: idle, synth on, stay transmit with preamble, receive; resets 0.
// (RL5) calibration field picks auto calibration on entering rx/tx or idle.
// (RL6) calibration 0 never, 1 leave idle, 2 auto idle, 3 every fourth.
// (RL7) software must not pair transmit-after-receive with clear-channel reliance.
module radio_state_policy_config (
  // clock and reset
  input  wire logic                              ref_clk_in,
  input  wire logic                              rst_in,
  // register port
  input  wire logic [radio_state_pkg::ADDR_W-1:0] reg_addr_in,
  input  wire logic [radio_state_pkg::DATA_W-1:0] reg_wdata_in,
  input  wire logic                              reg_write_in,
  input  wire logic                              reg_read_in,
  output logic      [radio_state_pkg::DATA_W-1:0] reg_rdata_out,
  // channel assessment inputs
  input  wire logic                              strength_below_thr_in,
  input  wire logic                              receiving_packet_in,
  output logic                                   clear_channel_indication_out,
  // packet completion events
  input  wire logic                              rx_done_in,
  input  wire logic                              tx_done_in,
  output radio_state_pkg::radio_state_t          next_state_out,
  output logic                                   next_state_valid_out,
  output logic                                   start_preamble_out,
  // calibration events
  input  wire logic                              leave_idle_in,
  input  wire logic                              auto_idle_in,
  input  wire logic                              calibrate_strobe_in,
  output logic                                   calibrate_req_out
);

  // ----------------------------------------------------------------
  // configuration fields
  // ----------------------------------------------------------------
  logic [1:0] clear_channel_criterion_r;
  logic [1:0] after_receive_state_r;
  logic [1:0] after_transmit_state_r;
  logic [1:0] synth_auto_calibration_r;
  logic [1:0] auto_idle_count_r;

  // map a two-bit state setting onto the radio state type
  function automatic radio_state_pkg::radio_state_t setting_to_state(input logic [1:0] s);
    case (s)
      2'h0:    setting_to_state = radio_state_pkg::ST_IDLE;
      2'h1:    setting_to_state = radio_state_pkg::ST_SYNTH_ON_FOR_TRANSMIT;
      2'h2:    setting_to_state = radio_state_pkg::ST_TRANSMIT;
      default: setting_to_state = radio_state_pkg::ST_RECEIVE;
    endcase
  endfunction : setting_to_state

  // register writes; unused bits ignored, other offsets ignored
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      clear_channel_criterion_r <= radio_state_pkg::CRITERION_RST; // see (RL2)
      after_receive_state_r     <= radio_state_pkg::AFTER_RX_RST;  // see (RL3)
      after_transmit_state_r    <= radio_state_pkg::AFTER_TX_RST;  // see (RL4)
      synth_auto_calibration_r  <= radio_state_pkg::AUTOCAL_RST;   // see (RL6)
    end else if (reg_write_in) begin
      if (reg_addr_in == radio_state_pkg::RADIO_STATE_CONFIG_1_OFS) begin
        clear_channel_criterion_r <= reg_wdata_in[radio_state_pkg::CRITERION_LSB +: 2];
        after_receive_state_r     <= reg_wdata_in[radio_state_pkg::AFTER_RX_LSB +: 2];
        after_transmit_state_r    <= reg_wdata_in[radio_state_pkg::AFTER_TX_LSB +: 2];
      end else if (reg_addr_in == radio_state_pkg::RADIO_STATE_CONFIG_0_OFS) begin
        synth_auto_calibration_r  <= reg_wdata_in[radio_state_pkg::AUTOCAL_LSB +: 2]; // see (RL5)
      end
    end
  end

  // readback one cycle after the read strobe; unmapped offsets read zero
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_read_in) begin
      if (reg_addr_in == radio_state_pkg::RADIO_STATE_CONFIG_1_OFS) begin
        reg_rdata_out <= {2'h0, clear_channel_criterion_r,
                          after_receive_state_r, after_transmit_state_r};
      end else if (reg_addr_in == radio_state_pkg::RADIO_STATE_CONFIG_0_OFS) begin
        reg_rdata_out <= {2'h0, synth_auto_calibration_r, 4'h0};
      end else begin
        reg_rdata_out <= 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // clear channel assessment
  // ----------------------------------------------------------------
  logic cca_nxt;

  // criterion decode, registered so the indication is glitch free
  always_comb begin
    case (clear_channel_criterion_r)
      radio_state_pkg::CRIT_ALWAYS:    cca_nxt = 1'b1;                    // see (RL1)
      radio_state_pkg::CRIT_BELOW_THR: cca_nxt = strength_below_thr_in;   // see (RL1)
      radio_state_pkg::CRIT_NOT_RX:    cca_nxt = !receiving_packet_in;    // see (RL1)
      default: cca_nxt = strength_below_thr_in && !receiving_packet_in;   // see (RL1)
    endcase
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      clear_channel_indication_out <= 1'b0;
    end else begin
      clear_channel_indication_out <= cca_nxt; // see (RL2)
    end
  end

  // ----------------------------------------------------------------
  // next state after a packet
  // ----------------------------------------------------------------
  // rx completion wins if both arrive at once; the radio cannot be in both
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      next_state_out       <= radio_state_pkg::ST_IDLE;
      next_state_valid_out <= 1'b0;
      start_preamble_out   <= 1'b0;
    end else begin
      next_state_valid_out <= rx_done_in || tx_done_in;
      start_preamble_out   <= 1'b0;
      if (rx_done_in) begin
        next_state_out <= setting_to_state(after_receive_state_r); // see (RL3)
      end else if (tx_done_in) begin
        // the after-transmit setting maps straight onto the state type, 3 being receive
        next_state_out     <= setting_to_state(after_transmit_state_r); // see (RL4)
        start_preamble_out <= (after_transmit_state_r == 2'h2); // see (RL4)
      end
    end
  end

  // ----------------------------------------------------------------
  // automatic synthesizer calibration
  // ----------------------------------------------------------------
  // counts automatic returns to idle; only used by the every-fourth setting
  // not cleared on a setting change, so the first fourth return may come early
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      auto_idle_count_r <= 2'h0;
    end else if (auto_idle_in) begin
      auto_idle_count_r <= auto_idle_count_r + 2'h1; // wraps after four
    end
  end

  // manual strobe always calibrates, whatever the automatic setting
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      calibrate_req_out <= 1'b0;
    end else begin
      case (synth_auto_calibration_r)
        radio_state_pkg::CAL_LEAVE_IDLE:
          calibrate_req_out <= calibrate_strobe_in || leave_idle_in; // see (RL6)
        radio_state_pkg::CAL_AUTO_IDLE:
          calibrate_req_out <= calibrate_strobe_in || auto_idle_in;  // see (RL6)
        radio_state_pkg::CAL_FOURTH_IDLE:
          calibrate_req_out <= calibrate_strobe_in || (auto_idle_in &&
                               auto_idle_count_r == radio_state_pkg::FOURTH_LAST); // see (RL6)
        default:
          calibrate_req_out <= calibrate_strobe_in; // see (RL6)
      endcase
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  cca_both_a: assert property ((clear_channel_criterion_r == 2'h3) ##1 // see (RL1)
      (clear_channel_criterion_r == 2'h3) |-> clear_channel_indication_out ==
      ($past(strength_below_thr_in) && !$past(receiving_packet_in)))
    else $error("clear channel wrong for both criterion");
  cca_always_a: assert property ((clear_channel_criterion_r == 2'h0) |=> // see (RL1)
      clear_channel_indication_out)
    else $error("clear channel not set for always criterion");
  cca_rx_a: assert property ((clear_channel_criterion_r == 2'h2 && receiving_packet_in) |=> // see (RL2)
      !clear_channel_indication_out)
    else $error("clear channel shown while receiving");
  rx_next_a: assert property (rx_done_in |=> next_state_valid_out && // see (RL3)
      next_state_out == setting_to_state($past(after_receive_state_r)))
    else $error("wrong state after receive");
  tx_next_a: assert property ((tx_done_in && !rx_done_in) |=> next_state_valid_out && // see (RL4)
      next_state_out == setting_to_state($past(after_transmit_state_r)))
    else $error("wrong state after transmit");
  preamble_a: assert property (start_preamble_out |-> next_state_out == // see (RL4)
      radio_state_pkg::ST_TRANSMIT)
    else $error("preamble without staying in transmit");
  cal_never_a: assert property ((synth_auto_calibration_r == 2'h0 && !calibrate_strobe_in) // see (RL6)
      |=> !calibrate_req_out)
    else $error("calibration with setting never");
  cal_leave_a: assert property ((synth_auto_calibration_r == 2'h1 && leave_idle_in) // see (RL5)
      |=> calibrate_req_out)
    else $error("no calibration on leaving idle");
  cal_fourth_a: assert property ((synth_auto_calibration_r == 2'h3 && auto_idle_in && // see (RL6)
      auto_idle_count_r != 2'h3 && !calibrate_strobe_in) |=> !calibrate_req_out)
    else $error("calibration before fourth return");
  // the indication flop is one cycle behind, so compare against last cycle's inputs
  cca_below_a: assert property ((clear_channel_criterion_r == 2'h1) |=> // see (RL1)
      clear_channel_indication_out == $past(strength_below_thr_in))
    else $error("clear channel wrong for strength criterion");
  cal_auto_a: assert property ((synth_auto_calibration_r == 2'h2 && auto_idle_in) // see (RL6)
      |=> calibrate_req_out)
    else $error("no calibration on automatic return to idle");
  strobe_cal_a: assert property (calibrate_strobe_in |=> calibrate_req_out) // see (RL6)
    else $error("manual strobe did not request calibration");
  preamble_rx_a: assert property (rx_done_in |=> !start_preamble_out) // see (RL4)
    else $error("preamble after a received packet");

  // main scenarios the bench is expected to reach
  rx_stay_c:   cover property (rx_done_in && after_receive_state_r == 2'h3);
  cal_leave_c: cover property (synth_auto_calibration_r == 2'h1 && leave_idle_in);
  tx_pre_c:    cover property (tx_done_in && after_transmit_state_r == 2'h2);
  cal_fourth_c: cover property (synth_auto_calibration_r == 2'h3 ##1 calibrate_req_out);
  cca_flip_c:  cover property (clear_channel_indication_out ##1 !clear_channel_indication_out);

endmodule : radio_state_policy_config

// File: test/radio_state_policy_config_bench.sv
// self-checking bench for the radio state policy configuration block
// assumes the block sits alone on one 25 MHz clock; bench drives every port directly
`timescale 1ns/1ns
module radio_state_policy_config_bench;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic       ref_clk_in = 1'b0;
  logic       rst_in = 1'b1;
  logic [5:0] reg_addr_in = 6'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic       reg_write_in = 1'b0, reg_read_in = 1'b0;
  logic       strength_below_thr_in = 1'b0, receiving_packet_in = 1'b0;
  logic       rx_done_in = 1'b0, tx_done_in = 1'b0;
  logic       leave_idle_in = 1'b0, auto_idle_in = 1'b0, calibrate_strobe_in = 1'b0;
  logic [7:0] reg_rdata_out;
  logic       clear_channel_indication_out, next_state_valid_out;
  logic       start_preamble_out, calibrate_req_out;
  logic       exp_clear, exp_cal;
  radio_state_pkg::radio_state_t next_state_out;
  int         mismatches = 0, n_checks = 0, seed = 32'ha233f32c;
  int         crit = 3, arx = 0, atx = 0, cal = 0, cnt = 0, r;
  // 40 ns period
  always #20 ref_clk_in = ~ref_clk_in;
  radio_state_policy_config uut (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
    .reg_rdata_out(reg_rdata_out), .strength_below_thr_in(strength_below_thr_in),
    .receiving_packet_in(receiving_packet_in),
    .clear_channel_indication_out(clear_channel_indication_out),
    .rx_done_in(rx_done_in), .tx_done_in(tx_done_in), .next_state_out(next_state_out),
    .next_state_valid_out(next_state_valid_out), .start_preamble_out(start_preamble_out),
    .leave_idle_in(leave_idle_in), .auto_idle_in(auto_idle_in),
    .calibrate_strobe_in(calibrate_strobe_in), .calibrate_req_out(calibrate_req_out));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // write strobe lasts one cycle; model fields follow the register layout
  task wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge ref_clk_in);
    reg_addr_in = a; reg_wdata_in = d; reg_write_in = 1'b1;
    @(negedge ref_clk_in);
    reg_write_in = 1'b0;
    if (a == 6'h17) begin crit = d[5:4]; arx = d[3:2]; atx = d[1:0]; end
    else if (a == 6'h18) cal = d[5:4];
  endtask : wr
  // unused bits and unmapped offsets read as zero
  task rd(input logic [5:0] a);
    logic [7:0] e;
    e = (a == 6'h17) ? {2'h0, 2'(crit), 2'(arx), 2'(atx)}
      : (a == 6'h18) ? {2'h0, 2'(cal), 4'h0} : 8'h00;
    @(negedge ref_clk_in);
    reg_addr_in = a; reg_read_in = 1'b1;
    @(negedge ref_clk_in);
    reg_read_in = 1'b0;
    chk(reg_rdata_out, e);
  endtask : rd
  // rx wins when both complete together; preamble only for tx with setting 2
  task done(input logic rx, input logic tx);
    @(negedge ref_clk_in);
    rx_done_in = rx; tx_done_in = tx;
    @(negedge ref_clk_in);
    rx_done_in = 1'b0; tx_done_in = 1'b0;
    chk({6'h00, next_state_out}, rx ? 8'(arx) : 8'(atx));
    chk({start_preamble_out, next_state_valid_out}, {!rx && atx == 2, 1'b1});
    @(negedge ref_clk_in);
    chk({start_preamble_out, next_state_valid_out}, 8'h00);
  endtask : done
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    chk({clear_channel_indication_out, calibrate_req_out, next_state_valid_out},
        8'h00);
    rst_in = 1'b0;
    rd(6'h17);
    rd(6'h18);
    wr(6'h20, 8'hff);
    rd(6'h20);
    rd(6'h17);
    // every criterion and every calibration setting, random traffic
    for (int m = 0; m < 4; m++) begin
      r = $random(seed);
      // receive setting kept at idle or stay-receive while the criterion is in use
      wr(6'h17, {r[7:6], 2'(m), {2{r[3]}}, r[1:0]});
      wr(6'h18, {r[15:14], 2'(m), r[11:8]});
      rd(6'h17);
      rd(6'h18);
      for (int i = 0; i < 40; i++) begin
        @(negedge ref_clk_in);
        if (i > 0) chk({clear_channel_indication_out, calibrate_req_out},
                       {exp_clear, exp_cal});
        r = $random(seed);
        strength_below_thr_in = r[0]; receiving_packet_in = r[1];
        leave_idle_in = r[2]; auto_idle_in = r[3]; calibrate_strobe_in = r[6:4] == 3'h0;
        exp_clear = (crit == 0) || (crit == 1 && r[0]) || (crit == 2 && !r[1])
                  || (crit == 3 && r[0] && !r[1]);
        exp_cal = calibrate_strobe_in || (cal == 1 && r[2]) || (cal == 2 && r[3])
                || (cal == 3 && r[3] && cnt == 3);
        if (r[3]) cnt = (cnt + 1) % 4;
      end
      @(negedge ref_clk_in);
      chk({clear_channel_indication_out, calibrate_req_out},
          {exp_clear, exp_cal});
      {leave_idle_in, auto_idle_in, calibrate_strobe_in} = 3'h0;
      // every next-state setting after receive and after transmit
      for (int k = 0; k < 4; k++) begin
        // criterion always-clear whenever receive is followed by transmit or synth on
        wr(6'h17, {2'h0, (k == 1 || k == 2) ? 2'h0 : 2'h3, 2'(k), 2'(3 - k)});
        done(1'b1, 1'b0);
        done(1'b0, 1'b1);
      end
      done(1'b1, 1'b1);
    end
    end_sim;
  end
  // watchdog, well beyond the few hundred cycles the sequence needs
  initial begin
    #400000;
    mismatches++;
    end_sim;
  end
endmodule : radio_state_policy_config_bench
